// ### rtl/cfg_loader_pkg.sv
/*
 * Shared constants, state and carrier types of the serial flash configuration loader.
 * Assumes a 125 MHz core clock and a mode-0 serial flash with a 3-byte address.
 */
package cfg_loader_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int MCLK_KHZ      = 125000;               // core clock rate
    localparam int MCLK_PS       = 8000;                 // core clock period
    localparam int SPI_KHZ       = 33300;                // nominal flash clock
    // divider rounds up so the flash clock never runs above nominal
    localparam int SCLK_DIV      = (MCLK_KHZ + SPI_KHZ - 1) / SPI_KHZ;
    localparam int SCLK_HALF     = SCLK_DIV / 2;
    localparam int CS_HIGH_NS    = 50;                   // least chip select high time
    localparam int CS_GAP_CYC    = (CS_HIGH_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
    localparam int LOCK_EDGES    = 64;                   // reference edges until multiplier lock

    // ************************************************************
    // flash geometry and commands
    // ************************************************************
    localparam int FLASH_BYTES   = 2097152;              // 16 Mbit store
    localparam int ADDR_W        = 21;                   // byte address width
    localparam int HDR_BITS      = 40;                   // opcode, address, dummy byte
    localparam int PP_HDR_BITS   = 32;                   // opcode and address
    localparam logic [7:0] OP_FAST_READ    = 8'h0b;
    localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [23:0] LOAD_START_ADDR = 24'h000000;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic RST_BUSY    = 1'b1;                 // status pin busy from reset
    localparam logic RST_CS_N    = 1'b1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_LOCK, ST_RD_HDR, ST_RD_DATA, ST_INIT, ST_READY,
        ST_WREN, ST_WGAP, ST_PP_HDR, ST_PP_DATA
    } ldr_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } cfg_word_t;

endpackage

// ### rtl/spi_flash_config_loader.sv
/*
 * Boot-time loader: reads the whole configuration flash after reset and
 * streams the bytes out, then offers page programming to the control side.
 * Assumes mclk is the multiplied reference clock, hold and write-protect pulled
 * up on the board, and pin-level tristate resolved by the surroundings.
 */
// Overview of operation
// - Master the flash in SPI mode 0 with one fixed clock near 33.3 MHz.
// - The load address range spans the whole 16 Mbit flash.
// - After reset release read the flash contents and then run initialization on them.
// - Hold the status pin high during initialization and drop it when it is finished.
// - Never send the slow read or signature commands and never change the clock rate.
// - Host programming of the flash uses page program commands.
// - Hold and write-protect pins of the flash are left undriven.
// - Flash timing derives from the single reference clock.
// - Wait for the clock multiplier lock before loading begins.
// - Flash clock, data out and chip select float while reset is asserted.
`timescale 1ns/1ps
module spi_flash_config_loader
    import cfg_loader_pkg::*;
#(
    parameter int unsigned LOAD_BYTES = FLASH_BYTES
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              reference_clock_in,
    input  wire logic              flash_serial_in,
    output logic                   flash_serial_clock,
    output logic                   flash_serial_clock_oe,
    output logic                   flash_serial_out,
    output logic                   flash_serial_out_oe,
    output logic                   flash_chip_select_n,
    output logic                   flash_chip_select_oe,
    output logic                   init_status_pin,
    input  wire logic              init_routine_done,
    output cfg_word_t              cfg_word,
    output logic                   cfg_valid,
    input  wire logic              prog_start,
    input  wire logic [ADDR_W-1:0] prog_addr,
    input  wire logic [7:0]        prog_byte,
    input  wire logic              prog_valid,
    input  wire logic              prog_last,
    output logic                   prog_ready
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic ref_m_q, ref_s_q, ref_p_q;
    logic miso_m_q, miso_s_q;

    // two stages for the reference clock and the flash data line;
    // the edge stage resets high, yet a reference already high at release still counts as an edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ref_m_q  <= 1'b0;
            ref_s_q  <= 1'b0;
            ref_p_q  <= 1'b1;
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else if (clk_en) begin
            ref_m_q  <= reference_clock_in;
            ref_s_q  <= ref_m_q;
            ref_p_q  <= ref_s_q;
            miso_m_q <= flash_serial_in;
            miso_s_q <= miso_m_q;
        end
    end

    // ************************************************************
    // sequencer and shifter
    // ************************************************************
    ldr_state_t              st_q, st_d;
    logic [2:0]              div_q, div_d;
    logic [5:0]              bits_q, bits_d;
    logic [HDR_BITS-1:0]     tx_q, tx_d;
    logic [6:0]              rx_q, rx_d;
    logic [6:0]              lock_q, lock_d;
    logic [3:0]              gap_q, gap_d;
    logic [ADDR_W-1:0]       addr_q, addr_d;
    logic [ADDR_W-1:0]       pa_q, pa_d;
    logic [ADDR_W:0]         left_q, left_d;
    logic                    last_q, last_d;
    logic                    sclk_q, sclk_d;
    logic                    mosi_q, mosi_d;
    logic                    cs_n_q, cs_n_d;
    logic                    oe_q;
    logic                    busy_q, busy_d;
    cfg_word_t               word_q, word_d;
    logic                    valid_q, valid_d;
    logic                    shifting, bit_end, byte_end, ref_rise;

    assign shifting   = bits_q != 6'h00;
    assign bit_end    = shifting && (div_q == 3'(SCLK_DIV - 1));
    assign byte_end   = bit_end && (bits_q == 6'h01);
    assign ref_rise   = ref_s_q && !ref_p_q;
    assign prog_ready = (st_q == ST_PP_DATA) && !shifting;

    // next values of the sequencer
    always_comb begin
        st_d    = st_q;
        div_d   = div_q;
        bits_d  = bits_q;
        tx_d    = tx_q;
        rx_d    = rx_q;
        lock_d  = lock_q;
        gap_d   = gap_q;
        addr_d  = addr_q;
        pa_d    = pa_q;
        left_d  = left_q;
        last_d  = last_q;
        cs_n_d  = cs_n_q;
        busy_d  = busy_q;
        word_d  = word_q;
        valid_d = 1'b0;
        // one bit per SCLK_DIV cycles, output moves on the falling edge
        if (shifting) begin
            div_d = bit_end ? 3'h0 : div_q + 3'h1;
        end
        if (bit_end) begin
            bits_d = bits_q - 6'h01;
            tx_d   = {tx_q[HDR_BITS-2:0], 1'b0};
            rx_d   = {rx_q[5:0], miso_s_q};
        end
        unique case (st_q)
            ST_LOCK: begin
                if (ref_rise) begin
                    lock_d = lock_q + 7'h01;
                end
                if (ref_rise && lock_q == 7'(LOCK_EDGES - 1)) begin
                    st_d   = ST_RD_HDR;
                    cs_n_d = 1'b0;
                    tx_d   = {OP_FAST_READ, LOAD_START_ADDR, 8'h00};
                    bits_d = 6'(HDR_BITS);
                end
            end
            ST_RD_HDR: begin
                if (byte_end) begin
                    st_d   = ST_RD_DATA;
                    bits_d = 6'h08;
                end
            end
            ST_RD_DATA: begin
                // no further address: the flash advances by itself
                if (byte_end) begin
                    valid_d     = 1'b1;
                    word_d.data = {rx_q, miso_s_q};
                    word_d.addr = addr_q;
                    addr_d      = addr_q + ADDR_W'(1);
                    left_d      = left_q - (ADDR_W+1)'(1);
                    if (left_q == (ADDR_W+1)'(1)) begin
                        st_d   = ST_INIT;
                        cs_n_d = 1'b1;
                    end else begin
                        bits_d = 6'h08;
                    end
                end
            end
            ST_INIT: begin
                gap_d = 4'h0;
                if (init_routine_done) begin
                    st_d   = ST_READY;
                    busy_d = 1'b0;
                end
            end
            ST_READY: begin
                if (gap_q != 4'(CS_GAP_CYC - 1)) begin
                    gap_d = gap_q + 4'h1;
                end else if (prog_start) begin
                    st_d   = ST_WREN;
                    cs_n_d = 1'b0;
                    tx_d   = {OP_WRITE_ENABLE, 32'h0};
                    bits_d = 6'h08;
                    pa_d   = prog_addr;
                end
            end
            ST_WREN: begin
                gap_d = 4'h0;
                if (byte_end) begin
                    st_d   = ST_WGAP;
                    cs_n_d = 1'b1;
                end
            end
            ST_WGAP: begin
                gap_d = gap_q + 4'h1;
                if (gap_q == 4'(CS_GAP_CYC - 1)) begin
                    st_d   = ST_PP_HDR;
                    cs_n_d = 1'b0;
                    last_d = 1'b0;
                    tx_d   = {OP_PAGE_PROG, 3'h0, pa_q, 8'h00};
                    bits_d = 6'(PP_HDR_BITS);
                end
            end
            ST_PP_HDR: begin
                if (byte_end) begin
                    st_d = ST_PP_DATA;
                end
            end
            ST_PP_DATA: begin
                gap_d = 4'h0;
                if (prog_valid && prog_ready) begin
                    tx_d   = {prog_byte, 32'h0};
                    bits_d = 6'h08;
                    last_d = prog_last;
                end
                if (byte_end && last_q) begin
                    st_d   = ST_READY;
                    cs_n_d = 1'b1;
                end
            end
        endcase
        sclk_d = shifting && !bit_end && (div_q + 3'h1 >= 3'(SCLK_HALF));
        mosi_d = tx_d[HDR_BITS-1];
    end

    // registers of the sequencer; pad drivers enable one edge after release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= ST_LOCK;
            div_q   <= 3'h0;
            bits_q  <= 6'h00;
            tx_q    <= '0;
            rx_q    <= 7'h00;
            lock_q  <= 7'h00;
            gap_q   <= 4'h0;
            addr_q  <= '0;
            pa_q    <= '0;
            left_q  <= (ADDR_W+1)'(LOAD_BYTES);
            last_q  <= 1'b0;
            sclk_q  <= 1'b0;
            mosi_q  <= 1'b0;
            cs_n_q  <= RST_CS_N;
            oe_q    <= 1'b0;
            busy_q  <= RST_BUSY;
            word_q  <= '0;
            valid_q <= 1'b0;
        end else if (clk_en) begin
            st_q    <= st_d;
            div_q   <= div_d;
            bits_q  <= bits_d;
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            lock_q  <= lock_d;
            gap_q   <= gap_d;
            addr_q  <= addr_d;
            pa_q    <= pa_d;
            left_q  <= left_d;
            last_q  <= last_d;
            sclk_q  <= sclk_d;
            mosi_q  <= mosi_d;
            cs_n_q  <= cs_n_d;
            oe_q    <= 1'b1;
            busy_q  <= busy_d;
            word_q  <= word_d;
            valid_q <= valid_d;
        end
    end

    // pin drive; there are no hold or write-protect outputs at all
    assign flash_serial_clock    = sclk_q;
    assign flash_serial_out      = mosi_q;
    assign flash_chip_select_n   = cs_n_q;
    assign flash_serial_clock_oe = oe_q;
    assign flash_serial_out_oe   = oe_q;
    assign flash_chip_select_oe  = oe_q;
    assign init_status_pin       = busy_q;
    assign cfg_word              = word_q;
    assign cfg_valid             = valid_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_idle_low; cs_n_q |-> !sclk_q; endproperty
    a_idle_low: assert property (p_idle_low) else $error("clock high outside frame");
    property p_mosi_stable; $rose(sclk_q) |-> $stable(mosi_q); endproperty
    a_mosi_stable: assert property (p_mosi_stable) else $error("data moved on rise");
    property p_half_len; $rose(sclk_q) && clk_en |=> sclk_q; endproperty
    a_half_len: assert property (p_half_len) else $error("clock high too short");
    property p_oe_lock; !oe_q |-> st_q == ST_LOCK; endproperty
    a_oe_lock: assert property (p_oe_lock) else $error("pins floating while active");
    property p_busy; busy_q == (st_q inside {ST_LOCK, ST_RD_HDR, ST_RD_DATA, ST_INIT});
    endproperty
    a_busy: assert property (p_busy) else $error("status pin wrong");
    property p_lock_first;
        st_q == ST_RD_HDR && $past(st_q) == ST_LOCK |-> lock_q == 7'(LOCK_EDGES - 1) + 7'h01;
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("load before lock");
    property p_rd_op;
        st_q == ST_RD_HDR && $past(st_q) == ST_LOCK |-> tx_q[39:32] == OP_FAST_READ && !cs_n_q;
    endproperty
    a_rd_op: assert property (p_rd_op) else $error("wrong read opcode");
    property p_pp_op;
        st_q == ST_PP_HDR && $past(st_q) == ST_WGAP |-> tx_q[39:32] == OP_PAGE_PROG;
    endproperty
    a_pp_op: assert property (p_pp_op) else $error("wrong program opcode");
    property p_frame_end;
        st_q == ST_INIT && $past(st_q) == ST_RD_DATA |-> cs_n_q && $past(valid_d);
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame not closed");
    property p_addr_step; valid_q |-> word_q.addr + ADDR_W'(1) == addr_q; endproperty
    a_addr_step: assert property (p_addr_step) else $error("address did not step");

    c_load_done: cover property (st_q == ST_INIT && $past(st_q) == ST_RD_DATA);
    c_ready:     cover property ($fell(init_status_pin));
    c_prog_done: cover property (st_q == ST_READY && $past(st_q) == ST_PP_DATA);

endmodule // spi_flash_config_loader

// ### verification/flash_model.sv
/*
 * Behavioural mode-0 serial flash standing at the loader's far side.
 * Assumes pins already resolved by the bench, chip select pulled high.
 */
`timescale 1ns/1ps
module flash_model
    import cfg_loader_pkg::*;
(
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0]  ops[$];
    logic [23:0] addrs[$];
    logic [7:0]  wr[$];
    int          nbits[$];
    int          viol;
    int          n;
    int          k;
    logic [39:0] sh;
    logic [7:0]  rd;
    realtime     last_rise;
    realtime     min_per;

    initial begin
        miso = 1'b0;
        viol = 0;
        n = 0;
        last_rise = 0.0;
        min_per = 1.0e9;
    end
    // frame opens only with the clock idle low
    always @(negedge cs_n) begin
        n = 0;
        if (sclk !== 1'b0) viol++;
    end
    // shift in on rising clock, log opcode, address and written bytes
    always @(posedge sclk) if (cs_n === 1'b0) begin
        if (last_rise > 0.0 && $realtime - last_rise < min_per) min_per = $realtime - last_rise;
        last_rise = $realtime;
        sh = {sh[38:0], mosi};
        n++;
        if (n == 8) ops.push_back(sh[7:0]);
        if (n == 8 && (sh[7:0] == 8'h03 || sh[7:0] == 8'h9f)) viol++;
        if (n == 32) addrs.push_back(sh[23:0]);
        if (n > 32 && n % 8 == 0 && ops[$] == OP_PAGE_PROG) wr.push_back(sh[7:0]);
    end
    // stream bytes with the address advancing by itself, msb first
    always @(negedge sclk) if (cs_n === 1'b0 && n >= 40 && ops[$] == OP_FAST_READ) begin
        k = n - 40;
        rd = 8'(addrs[$] + 24'(k / 8)) * 8'h1d + 8'h3c;
        miso <= rd[7 - k % 8];
    end
    // released line shows the opposite of its last value
    always @(posedge cs_n) begin
        nbits.push_back(n);
        if (sclk !== 1'b0) viol++;
        #1 miso = ~miso; // after any shift from the closing clock edge
    end
endmodule // flash_model

// ### verification/testbench.sv
/*
 * Self-checking bench of the configuration loader with a flash model.
 * Assumes flash pins pulled: chip select high, clock low, data out high.
 */
`timescale 1ns/1ps
module testbench;
    import cfg_loader_pkg::*;
    localparam int NB = 4;
    logic mclk, reset_n, clk_en, reference_clock_in, flash_serial_in, init_routine_done;
    logic flash_serial_clock, flash_serial_clock_oe, flash_serial_out, flash_serial_out_oe;
    logic flash_chip_select_n, flash_chip_select_oe, init_status_pin, cfg_valid;
    logic prog_start, prog_valid, prog_last, prog_ready;
    logic [ADDR_W-1:0] prog_addr;
    logic [7:0]        prog_byte;
    cfg_word_t         cfg_word;
    int                num_errors, n_compared;
    realtime           t_rel;
    // pin levels; hold and write-protect sit on board pull-ups, no ports here
    wire sclk_pin = flash_serial_clock_oe ? flash_serial_clock : 1'b0;
    wire mosi_pin = flash_serial_out_oe ? flash_serial_out : 1'b1;
    wire cs_pin   = flash_chip_select_oe ? flash_chip_select_n : 1'b1;

    spi_flash_config_loader #(.LOAD_BYTES(NB)) spi_flash_config_loader_inst (
        .mclk, .reset_n, .clk_en, .reference_clock_in, .flash_serial_in,
        .flash_serial_clock, .flash_serial_clock_oe, .flash_serial_out, .flash_serial_out_oe,
        .flash_chip_select_n, .flash_chip_select_oe, .init_status_pin, .init_routine_done,
        .cfg_word, .cfg_valid, .prog_start, .prog_addr, .prog_byte, .prog_valid, .prog_last,
        .prog_ready);
    flash_model flash_model_inst (.cs_n(cs_pin), .sclk(sclk_pin), .mosi(mosi_pin),
        .miso(flash_serial_in));

    // core clock and free-running reference
    always #4 mclk = ~mclk;
    always #62.5 reference_clock_in = ~reference_clock_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic test_done;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // hold reset for 20 cycles, pins must float meanwhile
    task automatic do_reset;
        @(posedge mclk) reset_n <= 1'b0;
        init_routine_done <= 1'b0;
        repeat (20) @(posedge mclk);
        check({flash_serial_clock_oe, flash_serial_out_oe, flash_chip_select_oe}, 0, "pin driven");
        check(init_status_pin, 1, "status low in reset");
        flash_model_inst.ops.delete();
        flash_model_inst.nbits.delete();
        flash_model_inst.addrs.delete();
        flash_model_inst.viol = 0; // forget pin glitches while outputs were unknown
        reset_n <= 1'b1;
        t_rel = $realtime;
    endtask

    // whole load after lock, then the status handshake
    task automatic load_and_init;
        int i, k;
        i = 0;
        for (k = 0; k < 3000 && flash_chip_select_n !== 1'b0; k++) @(negedge mclk);
        check($realtime - t_rel >= (LOCK_EDGES - 1) * 125.0, 1, "load before lock");
        check({flash_serial_clock_oe, flash_serial_out_oe, flash_chip_select_oe}, 7, "pin idle");
        check(init_status_pin, 1, "status low in load");
        for (k = 0; k < 2000 && i < NB; k++) begin
            @(negedge mclk);
            if (cfg_valid === 1'b1) begin
                check(cfg_word, {21'(i), 8'(i * 29 + 60)}, "load byte");
                i++;
            end
        end
        check(i, NB, "byte count");
        @(negedge mclk);
        check(flash_chip_select_n, 1, "frame left open");
        check(flash_model_inst.ops[0], OP_FAST_READ, "read opcode");
        check(flash_model_inst.addrs[0], LOAD_START_ADDR, "start address");
        check(flash_model_inst.nbits[0], HDR_BITS + 8 * NB, "frame length");
        check(flash_model_inst.viol, 0, "mode or opcode");
        check(flash_model_inst.min_per >= 1.0e6 / 33300, 1, "clock too fast");
        check(FLASH_BYTES <= (1 << ADDR_W), 1, "address range");
        repeat (20) @(negedge mclk);
        check(init_status_pin, 1, "status low early");
        @(posedge mclk) init_routine_done <= 1'b1;
        for (k = 0; k < 4 && init_status_pin !== 1'b0; k++) @(negedge mclk);
        check(init_status_pin, 0, "status stuck");
    endtask

    // offer one program byte and hold it until taken
    task automatic send(input logic [7:0] b, input logic l);
        int k;
        prog_byte <= b;
        prog_last <= l;
        prog_valid <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(negedge mclk);
            if (prog_ready === 1'b1) break;
        end
        @(posedge mclk);
    endtask

    // page program of three bytes once status is low
    task automatic program_page;
        int k;
        flash_model_inst.ops.delete();
        flash_model_inst.nbits.delete();
        flash_model_inst.addrs.delete();
        @(posedge mclk) prog_start <= 1'b1;
        prog_addr <= 21'h1abcd;
        // hold the request until the frame opens; the loader waits out its gap first
        for (k = 0; k < 50 && flash_chip_select_n !== 1'b0; k++) @(negedge mclk);
        @(posedge mclk) prog_start <= 1'b0;
        for (k = 0; k < 3; k++) send(8'h5a + 8'(k * 17), k == 2);
        prog_valid <= 1'b0;
        prog_last <= 1'b0;
        for (k = 0; k < 100 && flash_chip_select_n !== 1'b1; k++) @(negedge mclk);
        check(flash_model_inst.ops[0], OP_WRITE_ENABLE, "enable opcode");
        check(flash_model_inst.viol, 0, "mode or opcode in program");
        check(flash_model_inst.ops[1], OP_PAGE_PROG, "program opcode");
        check(flash_model_inst.addrs[0], 24'h01abcd, "program address");
        check(flash_model_inst.nbits[1], PP_HDR_BITS + 24, "program length");
        for (k = 0; k < 3; k++) check(flash_model_inst.wr[k], 8'h5a + 8'(k * 17), "byte");
    endtask

    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        reference_clock_in = 1'b0;
        init_routine_done = 1'b0;
        prog_start = 1'b0;
        prog_valid = 1'b0;
        prog_last = 1'b0;
        prog_addr = '0;
        prog_byte = '0;
        num_errors = 0;
        n_compared = 0;
        do_reset;
        load_and_init;
        program_page;
        do_reset;
        load_and_init;
        test_done;
    end

    // cut a hang short well beyond the expected run
    initial begin
        #100000;
        num_errors++;
        $display("BAD %0t watchdog", $time);
        test_done;
    end
endmodule // testbench
